// ---- inc/seq_pkg.sv ----
// constants, types and helpers of the nand flow sequencer and its command queues
//
// Functional notes
// R1 - words 1-3,5,6 free; word 4 pushes
// R2 - one command queue per flash channel
// R3 - host checks queue not full first
// R4 - broadcast copies command into every queue; code skips a queue that is full
// R5 - host never shares buffer region between channels
// R6 - bus masters take buffer region in turn
// R7 - software sets ecc, scramble, timing first
// R8 - vendor-A SLC read: A2 prefix, four reads
// R9 - vendor-A SLC write: 85 spare, 11, 10
// R10 - TLC page reads use prefix 01/02/03
// R11 - TLC spare reads: single spare column change
// R12 - vendor-B SLC flows prefix DA, call routine
// R13 - vendor-B TLC flows prefix DF, erase DA; code gives TLC erase (0e) DF, only SLC erase (0d) DA
// R14 - page spare read routine does whole read
// R15 - loop repeats by counter; terminate frees slot
// R16 - call runs routine, resumes after its name
package seq_pkg;
	localparam int CH_N    = 4;    // flash channels
	localparam int CH_W    = 2;
	localparam int ST_W    = 3;    // staging slot index, broadcast slot last
	localparam int Q_DEPTH = 4;    // commands per channel queue
	localparam int QP_W    = 2;
	localparam int QC_W    = 3;
	localparam int PC_W    = 8;
	localparam int ROM_N   = 229;  // microcode words

	// command word numbers
	localparam logic [2:0] WSEL_ROW   = 3'h1;
	localparam logic [2:0] WSEL_COL   = 3'h2;
	localparam logic [2:0] WSEL_SPCOL = 3'h3;
	localparam logic [2:0] WSEL_PUSH  = 3'h4;
	localparam logic [2:0] WSEL_TOG   = 3'h5;
	localparam logic [2:0] WSEL_USER  = 3'h6;
	// fields of word 4
	localparam int F_CODE_LSB = 0;
	localparam int F_CNT_LSB  = 8;

	// flow codes
	localparam logic [7:0] FL_A_SLC_RD  = 8'h00;
	localparam logic [7:0] FL_A_SLC_WR  = 8'h01;
	localparam logic [7:0] FL_TLC_L_RD  = 8'h02;
	localparam logic [7:0] FL_TLC_U_RD  = 8'h04;
	localparam logic [7:0] FL_TLC_L_SP  = 8'h05;
	localparam logic [7:0] FL_TLC_U_SP  = 8'h07;
	localparam logic [7:0] FL_B_SLC_PRS = 8'h08;
	localparam logic [7:0] FL_B_SLC_ER  = 8'h0d;
	localparam logic [7:0] FL_B_TLC_ER  = 8'h0e;
	localparam logic [7:0] FL_B_TLC_PRS = 8'h0f;
	localparam logic [7:0] FL_B_TLC_SR  = 8'h10;
	localparam logic [7:0] FL_GET_FEAT  = 8'h11;
	localparam logic [7:0] FL_SET_FEAT  = 8'h12;

	// prefix bytes
	localparam logic [7:0] PFX_A     = 8'ha2;
	localparam logic [7:0] PFX_TLC_L = 8'h01;
	localparam logic [7:0] PFX_B_SLC = 8'hda;
	localparam logic [7:0] PFX_B_TLC = 8'hdf;

	// address and data selectors
	localparam logic [7:0] A_COL   = 8'h00;
	localparam logic [7:0] A_ROW   = 8'h01;
	localparam logic [7:0] A_ZERO  = 8'h02;
	localparam logic [7:0] A_SPCOL = 8'h03;
	localparam logic [7:0] A_TOG   = 8'h04;
	localparam logic [7:0] D_RD    = 8'h00;
	localparam logic [7:0] D_WD    = 8'h01;
	localparam logic [7:0] D_RDSP  = 8'h02;
	localparam logic [7:0] D_WRSP  = 8'h03;
	localparam logic [7:0] D_MST   = 8'h04;

	// microcode addresses of routines and flows
	localparam logic [7:0] RB_MRDST  = 8'd0;
	localparam logic [7:0] RB_PRS    = 8'd5;
	localparam logic [7:0] RB_SR     = 8'd24;
	localparam logic [7:0] RB_BR     = 8'd34;
	localparam logic [7:0] RB_PWS    = 8'd44;
	localparam logic [7:0] RB_BW     = 8'd54;
	localparam logic [7:0] RB_ER     = 8'd63;
	localparam logic [7:0] FB_B_PRS  = 8'd69;
	localparam logic [7:0] FB_B_SR   = 8'd73;
	localparam logic [7:0] FB_B_BR   = 8'd77;
	localparam logic [7:0] FB_B_PWS  = 8'd81;
	localparam logic [7:0] FB_B_BW   = 8'd85;
	localparam logic [7:0] FB_B_ER   = 8'd89;
	localparam logic [7:0] FB_A_RD   = 8'd93;
	localparam logic [7:0] FB_A_WR   = 8'd130;
	localparam logic [7:0] FB_TLC_RD = 8'd161;
	localparam logic [7:0] FB_TLC_SP = 8'd197;
	localparam logic [7:0] FB_GETF   = 8'd212;
	localparam logic [7:0] FB_SETF   = 8'd221;
	localparam logic [7:0] FB_BAD    = 8'd228;

	typedef enum logic [3:0] {
		K_OPC, K_PFX, K_ADR, K_DAT, K_BUF, K_CALL, K_NAME, K_RET, K_LOOP, K_END
	} step_kind_t;

	typedef struct packed {
		step_kind_t kind;
		logic [7:0] arg;
	} step_t;

	typedef struct packed {
		logic [31:0] user;
		logic [31:0] tog;
		logic [31:0] ctl;
		logic [31:0] spcol;
		logic [31:0] col;
		logic [31:0] row;
	} cmd_t;

	// microcode word builders
	function automatic step_t op(input logic [7:0] b);
		return '{K_OPC, b};
	endfunction : op
	function automatic step_t pf();
		return '{K_PFX, 8'h00};
	endfunction : pf
	function automatic step_t ad(input logic [7:0] s);
		return '{K_ADR, s};
	endfunction : ad
	function automatic step_t dt(input logic [7:0] s);
		return '{K_DAT, s};
	endfunction : dt
	function automatic step_t bf(input logic [7:0] n);
		return '{K_BUF, n};
	endfunction : bf
	function automatic step_t cl(input logic [7:0] a);
		return '{K_CALL, a};
	endfunction : cl
	function automatic step_t nm();
		return '{K_NAME, 8'h00};
	endfunction : nm
	function automatic step_t rt();
		return '{K_RET, 8'h00};
	endfunction : rt
	function automatic step_t lp();
		return '{K_LOOP, 8'h00};
	endfunction : lp
	function automatic step_t en();
		return '{K_END, 8'h00};
	endfunction : en

	// entry address of a flow code
	function automatic logic [7:0] flow_base(input logic [7:0] code);
		case (code)
			FL_A_SLC_RD: return FB_A_RD;
			FL_A_SLC_WR: return FB_A_WR;
			8'h02, 8'h03, 8'h04: return FB_TLC_RD;
			8'h05, 8'h06, 8'h07: return FB_TLC_SP;
			8'h08, FL_B_TLC_PRS: return FB_B_PRS;
			8'h09, FL_B_TLC_SR: return FB_B_SR;
			8'h0a: return FB_B_BR;
			8'h0b: return FB_B_PWS;
			8'h0c: return FB_B_BW;
			FL_B_SLC_ER, FL_B_TLC_ER: return FB_B_ER;
			FL_GET_FEAT: return FB_GETF;
			FL_SET_FEAT: return FB_SETF;
			default: return FB_BAD;
		endcase
	endfunction : flow_base

	// prefix byte issued by a prefix step of a flow code
	function automatic logic [7:0] flow_prefix(input logic [7:0] code);
		if (code >= FL_TLC_L_RD && code <= FL_TLC_U_RD)
			return PFX_TLC_L + (code - FL_TLC_L_RD);
		else if (code >= FL_TLC_L_SP && code <= FL_TLC_U_SP)
			return PFX_TLC_L + (code - FL_TLC_L_SP);
		else if (code >= FL_B_SLC_PRS && code <= FL_B_SLC_ER)
			return PFX_B_SLC;  // R12 R13
		else if (code >= FL_B_TLC_ER && code <= FL_B_TLC_SR)
			return PFX_B_TLC;  // R13
		else
			return 8'h00;
	endfunction : flow_prefix
endpackage : seq_pkg

// ---- inc/seq_rom_if.sv ----
// link between the sequencer and its microcode store
`timescale 1ns/10ps
interface seq_rom_if import seq_pkg::*; ();
	logic [PC_W-1:0] pc;      // step address
	logic [7:0]      code;    // flow code being looked up
	step_kind_t      kind;    // kind of the addressed step
	logic [7:0]      arg;     // argument of the addressed step
	logic [PC_W-1:0] base;    // entry address of code
	logic [7:0]      prefix;  // prefix byte of code
	modport rom (input pc, code, output kind, arg, base, prefix);
	modport seq (output pc, code, input kind, arg, base, prefix);
endinterface : seq_rom_if

// ---- rtl/flow_rom.sv ----
// microcode store of all flows and fixed routines
`timescale 1ns/10ps
module flow_rom import seq_pkg::*; (
	seq_rom_if.rom rif  // step and flow lookup
);
	localparam step_t ROM [0:ROM_N-1] = '{
		// status poll routine
		op(8'h70), bf(8'h04), dt(D_MST), bf(8'h03), rt(),
		// page spare read routine, the whole page plus spare read (R14)
		op(8'h00), ad(A_COL), ad(A_ROW), op(8'h30), cl(RB_MRDST), nm(),
		op(8'h05), ad(A_COL), op(8'he0), bf(8'h04), dt(D_RD), bf(8'h03),
		op(8'h05), ad(A_SPCOL), op(8'he0), bf(8'h04), dt(D_RDSP), bf(8'h03), rt(),
		// spare, byte read, page spare write, byte write, erase routines
		op(8'h00), ad(A_SPCOL), ad(A_ROW), op(8'h30), cl(RB_MRDST), nm(),
		bf(8'h04), dt(D_RDSP), bf(8'h03), rt(),
		op(8'h00), ad(A_COL), ad(A_ROW), op(8'h30), cl(RB_MRDST), nm(),
		bf(8'h04), dt(D_RDSP), bf(8'h03), rt(),
		op(8'h80), ad(A_COL), ad(A_ROW), bf(8'h01), dt(D_WD), dt(D_WRSP),
		op(8'h10), cl(RB_MRDST), nm(), rt(),
		op(8'h80), ad(A_COL), ad(A_ROW), bf(8'h01), dt(D_WRSP), op(8'h10),
		cl(RB_MRDST), nm(), rt(),
		op(8'h60), ad(A_ROW), op(8'hd0), cl(RB_MRDST), nm(), rt(),
		// vendor-B wrappers: prefix then fixed routine (R12)
		pf(), cl(RB_PRS), nm(), en(), pf(), cl(RB_SR), nm(), en(),
		pf(), cl(RB_BR), nm(), en(), pf(), cl(RB_PWS), nm(), en(),
		pf(), cl(RB_BW), nm(), en(), pf(), cl(RB_ER), nm(), en(),
		// vendor-A SLC page read with spare (R8)
		op(PFX_A), op(8'h00), ad(A_COL), ad(A_ROW), op(8'h30), cl(RB_MRDST), nm(),
		op(8'h05), ad(A_COL), ad(A_ROW), op(8'he0), bf(8'h04), dt(D_RD), bf(8'h03),
		op(8'h05), ad(A_SPCOL), ad(A_ROW), op(8'he0), bf(8'h04), dt(D_RDSP), bf(8'h03),
		op(8'h05), ad(A_ZERO), ad(A_TOG), op(8'he0), bf(8'h04), dt(D_RD), bf(8'h03),
		op(8'h05), ad(A_SPCOL), ad(A_TOG), op(8'he0), bf(8'h04), dt(D_RDSP), bf(8'h03),
		lp(), en(),
		// vendor-A SLC page write (R9)
		op(PFX_A), op(8'h80), ad(A_COL), ad(A_ROW), bf(8'h01), dt(D_WD), op(8'h85),
		bf(8'h04), ad(A_SPCOL), ad(A_ROW), bf(8'h01), dt(D_WRSP), op(8'h11),
		cl(RB_MRDST), nm(), op(8'h80), ad(A_ZERO), ad(A_TOG), bf(8'h01), dt(D_WD),
		op(8'h85), bf(8'h04), ad(A_SPCOL), ad(A_TOG), bf(8'h01), dt(D_WRSP),
		op(8'h10), cl(RB_MRDST), nm(), lp(), en(),
		// TLC page read with spare (R10)
		pf(), op(8'h00), ad(A_ZERO), ad(A_ROW), op(8'h30), cl(RB_MRDST), nm(),
		op(8'h05), ad(A_COL), ad(A_ROW), op(8'he0), bf(8'h04), dt(D_RD), bf(8'h03),
		op(8'h05), ad(A_SPCOL), ad(A_ROW), op(8'he0), bf(8'h04), dt(D_RDSP), bf(8'h03),
		op(8'h05), ad(A_ZERO), ad(A_TOG), op(8'he0), bf(8'h04), dt(D_RD), bf(8'h03),
		op(8'h05), ad(A_SPCOL), ad(A_TOG), op(8'he0), bf(8'h04), dt(D_RDSP), bf(8'h03),
		en(),
		// TLC spare read (R11)
		pf(), op(8'h00), ad(A_ZERO), ad(A_ROW), op(8'h30), cl(RB_MRDST), nm(),
		op(8'h05), ad(A_SPCOL), ad(A_ROW), op(8'he0), bf(8'h04), dt(D_RDSP), bf(8'h03),
		en(),
		// get feature, set feature, unknown code
		op(8'hee), ad(A_ROW), cl(RB_MRDST), nm(), op(8'h00), bf(8'h04), dt(D_RDSP),
		bf(8'h03), en(),
		op(8'hef), ad(A_ROW), bf(8'h01), dt(D_WRSP), cl(RB_MRDST), nm(), en(),
		en()
	};

	step_t word;

	// step fetch and flow lookup
	assign word       = (rif.pc < PC_W'(ROM_N)) ? ROM[rif.pc] : en();
	assign rif.kind   = word.kind;
	assign rif.arg    = word.arg;
	assign rif.base   = flow_base(rif.code);
	assign rif.prefix = flow_prefix(rif.code);
endmodule : flow_rom

// ---- rtl/nand_flow_sequencer_cmd_queue.sv ----
// per-channel command queues and the microcoded flow sequencer behind them
`timescale 1ns/10ps
module nand_flow_sequencer_cmd_queue import seq_pkg::*; (
	input  wire logic            clk,         // 50 MHz clock
	input  wire logic            sys_rst,     // synchronous reset, active high
	input  wire logic            cmd_wr,      // one-cycle command word write
	input  wire logic [2:0]      cmd_wsel,    // word number 1..6
	input  wire logic [CH_W-1:0] cmd_chan,    // target channel
	input  wire logic            cmd_bcast,   // write goes to the broadcast slot
	input  wire logic [31:0]     cmd_wdata,   // word value
	output logic [CH_N-1:0]      q_full,      // queue full per channel
	output logic [CH_N-1:0]      q_empty,     // queue empty per channel
	output logic                 step_valid,  // flash step offered
	output step_kind_t           step_kind,   // kind of the step
	output logic [7:0]           step_byte,   // opcode, prefix or selector
	output logic [31:0]          step_addr,   // address value of address steps
	output logic [CH_W-1:0]      step_chan,   // channel of the step
	input  wire logic            step_ready,  // channel engine takes the step
	output logic                 cmd_done,    // one-cycle pulse at flow end
	output logic [CH_W-1:0]      done_chan,   // channel whose command ended
	output logic                 busy         // a flow is running
);
	typedef enum logic [1:0] {S_IDLE, S_RUN, S_WAIT} seq_state_t;

	seq_rom_if rif ();
	flow_rom flow_rom_inst (.rif(rif.rom));

	cmd_t             stage_reg [0:CH_N];
	cmd_t             qmem_reg  [CH_N][Q_DEPTH];
	logic [QP_W-1:0]  wptr_reg  [CH_N];
	logic [QP_W-1:0]  rptr_reg  [CH_N];
	logic [QC_W-1:0]  qcnt_reg  [CH_N];
	logic [QC_W-1:0]  qcnt_next [CH_N];
	logic [CH_N-1:0]  push_ch;
	logic [CH_N-1:0]  pop_ch;
	logic [CH_N-1:0]  full_next;
	logic [CH_N-1:0]  empty_next;
	logic [CH_N-1:0]  q_full_reg;
	logic [CH_N-1:0]  q_empty_reg;
	cmd_t             new_cmd;
	cmd_t             head;
	cmd_t             cur_reg;
	seq_state_t       state_reg;
	logic [PC_W-1:0]  pc_reg;
	logic [PC_W-1:0]  stk_reg [2];
	logic [1:0]       sp_reg;
	logic [7:0]       cnt_reg;
	logic [CH_W-1:0]  cur_ch_reg;
	logic [CH_W-1:0]  rr_reg;
	logic [CH_W-1:0]  sel_ch;
	logic             sel_found;
	logic             step_valid_reg;
	step_kind_t       step_kind_reg;
	logic [7:0]       step_byte_reg;
	logic [31:0]      step_addr_reg;
	logic [CH_W-1:0]  step_chan_reg;
	logic             cmd_done_reg;
	logic [CH_W-1:0]  done_chan_reg;
	logic             busy_reg;
	logic [CH_N*QC_W-1:0] qcnt_flat;

	// word decode and sequencer step decode
	wire [ST_W-1:0]  stage_idx = cmd_bcast ? ST_W'(CH_N) : ST_W'(cmd_chan);
	wire             push_word = cmd_wr && (cmd_wsel == WSEL_PUSH);
	wire [7:0]       head_code = head.ctl[F_CODE_LSB +: 8];
	wire             start_evt = (state_reg == S_IDLE) && sel_found;
	wire             run       = (state_reg == S_RUN);
	wire             emit      = (rif.kind == K_OPC) || (rif.kind == K_PFX) ||
	                             (rif.kind == K_ADR) || (rif.kind == K_DAT) || (rif.kind == K_BUF);
	wire             ctl_step  = (rif.kind == K_CALL) || (rif.kind == K_RET) || (rif.kind == K_LOOP);
	wire             end_evt   = run && !emit && !ctl_step;  // R15
	wire [PC_W-1:0]  ret_pc    = stk_reg[~sp_reg[0]];
	wire [7:0]       byte_val  = (rif.kind == K_PFX) ? rif.prefix : rif.arg;
	wire [31:0]      addr_val  = (rif.arg == A_ROW)   ? cur_reg.row :
	                             (rif.arg == A_COL)   ? cur_reg.col :
	                             (rif.arg == A_SPCOL) ? cur_reg.spcol :
	                             (rif.arg == A_TOG)   ? cur_reg.tog : 32'h0000_0000;

	assign head     = qmem_reg[sel_ch][rptr_reg[sel_ch]];
	assign rif.pc   = pc_reg;
	assign rif.code = start_evt ? head_code : cur_reg.ctl[F_CODE_LSB +: 8];

	// outputs straight from their flip-flops
	assign q_full     = q_full_reg;
	assign q_empty    = q_empty_reg;
	assign step_valid = step_valid_reg;
	assign step_kind  = step_kind_reg;
	assign step_byte  = step_byte_reg;
	assign step_addr  = step_addr_reg;
	assign step_chan  = step_chan_reg;
	assign cmd_done   = cmd_done_reg;
	assign done_chan  = done_chan_reg;
	assign busy       = busy_reg;

	// assembled command: staged words plus word 4 as it is written
	always_comb begin
		new_cmd     = stage_reg[stage_idx];
		new_cmd.ctl = cmd_wdata;
	end

	// push, pop and occupancy per channel; a full queue drops the push
	always_comb begin
		for (int c = 0; c < CH_N; c++) begin
			push_ch[c]   = push_word && (cmd_bcast || (cmd_chan == CH_W'(c))) &&
			               (qcnt_reg[c] != QC_W'(Q_DEPTH));  // R4
			pop_ch[c]    = end_evt && (cur_ch_reg == CH_W'(c));  // R15
			qcnt_next[c] = QC_W'(qcnt_reg[c] + QC_W'(push_ch[c]) - QC_W'(pop_ch[c]));
			full_next[c] = (qcnt_next[c] == QC_W'(Q_DEPTH));
			empty_next[c] = (qcnt_next[c] == '0);
			qcnt_flat[c*QC_W +: QC_W] = qcnt_reg[c];
		end
	end

	// round-robin pick of the next non-empty queue
	always_comb begin
		sel_found = 1'b0;
		sel_ch    = rr_reg;
		for (int i = CH_N - 1; i >= 0; i--) begin
			if (qcnt_reg[CH_W'(rr_reg + CH_W'(i))] != '0) begin
				sel_found = 1'b1;
				sel_ch    = CH_W'(rr_reg + CH_W'(i));
			end
		end
	end

	// staging slots: words other than 4 may be rewritten at will
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int s = 0; s <= CH_N; s++) stage_reg[s] <= '0;
		end else if (cmd_wr) begin
			case (cmd_wsel)  // R1
				WSEL_ROW:   stage_reg[stage_idx].row   <= cmd_wdata;
				WSEL_COL:   stage_reg[stage_idx].col   <= cmd_wdata;
				WSEL_SPCOL: stage_reg[stage_idx].spcol <= cmd_wdata;
				WSEL_TOG:   stage_reg[stage_idx].tog   <= cmd_wdata;
				WSEL_USER:  stage_reg[stage_idx].user  <= cmd_wdata;
				default:    stage_reg[stage_idx].ctl   <= cmd_wdata;
			endcase
		end
	end

	// queue storage, one ring per channel
	always_ff @(posedge clk) begin
		for (int c = 0; c < CH_N; c++) begin
			if (push_ch[c]) qmem_reg[c][wptr_reg[c]] <= new_cmd;  // R2
		end
	end

	// queue pointers and status flags
	always_ff @(posedge clk) begin
		for (int c = 0; c < CH_N; c++) begin
			if (sys_rst) begin
				wptr_reg[c] <= '0;
				rptr_reg[c] <= '0;
				qcnt_reg[c] <= '0;
			end else begin
				wptr_reg[c] <= QP_W'(wptr_reg[c] + QP_W'(push_ch[c]));  // R1
				rptr_reg[c] <= QP_W'(rptr_reg[c] + QP_W'(pop_ch[c]));  // R15
				qcnt_reg[c] <= qcnt_next[c];
			end
		end
		q_full_reg  <= sys_rst ? '0 : full_next;
		q_empty_reg <= sys_rst ? '1 : empty_next;
	end

	// flow sequencer: fetch, emit with handshake, call, return, loop, end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_reg      <= S_IDLE;
			pc_reg         <= '0;
			sp_reg         <= '0;
			stk_reg[0]     <= '0;
			stk_reg[1]     <= '0;
			cnt_reg        <= '0;
			cur_reg        <= '0;
			cur_ch_reg     <= '0;
			rr_reg         <= '0;
			step_valid_reg <= 1'b0;
			step_kind_reg  <= K_OPC;
			step_byte_reg  <= '0;
			step_addr_reg  <= '0;
			step_chan_reg  <= '0;
			cmd_done_reg   <= 1'b0;
			done_chan_reg  <= '0;
			busy_reg       <= 1'b0;
		end else begin
			cmd_done_reg <= end_evt;
			if (end_evt) done_chan_reg <= cur_ch_reg;
			case (state_reg)
				S_IDLE: if (sel_found) begin
					cur_reg    <= head;
					cur_ch_reg <= sel_ch;
					cnt_reg    <= head.ctl[F_CNT_LSB +: 8];
					pc_reg     <= rif.base;
					sp_reg     <= '0;
					rr_reg     <= CH_W'(sel_ch + CH_W'(1));
					busy_reg   <= 1'b1;
					state_reg  <= S_RUN;
				end
				S_RUN: if (emit) begin
					step_valid_reg <= 1'b1;
					step_kind_reg  <= rif.kind;
					step_byte_reg  <= byte_val;  // R10
					step_addr_reg  <= addr_val;
					step_chan_reg  <= cur_ch_reg;  // R2
					state_reg      <= S_WAIT;
				end else if (rif.kind == K_CALL) begin
					stk_reg[sp_reg[0]] <= PC_W'(pc_reg + PC_W'(2));  // R16
					sp_reg             <= sp_reg + 2'h1;
					pc_reg             <= rif.arg;  // R16
				end else if (rif.kind == K_RET) begin
					pc_reg <= ret_pc;  // R16
					sp_reg <= sp_reg - 2'h1;
				end else if (rif.kind == K_LOOP) begin
					if (cnt_reg > 8'h01) begin
						cnt_reg <= cnt_reg - 8'h01;  // R15
						pc_reg  <= rif.base;
					end else begin
						pc_reg <= PC_W'(pc_reg + PC_W'(1));
					end
				end else begin
					busy_reg  <= 1'b0;  // R15
					state_reg <= S_IDLE;
				end
				S_WAIT: if (step_ready) begin
					step_valid_reg <= 1'b0;
					pc_reg         <= PC_W'(pc_reg + PC_W'(1));
					state_reg      <= S_RUN;
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end

	// checks on queue and sequencer behaviour
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	AST_NO_PUSH_OTHER: assert property ( // R1
		cmd_wr && (cmd_wsel != WSEL_PUSH) && !end_evt |=> $stable(qcnt_flat))
		else $error("queue changed on a word other than 4");
	AST_PUSH_W4: assert property ( // R1
		push_word && !cmd_bcast && !q_full_reg[cmd_chan] && !end_evt
		|=> qcnt_reg[$past(cmd_chan)] == $past(qcnt_reg[cmd_chan]) + 1)
		else $error("word 4 did not push one command");
	AST_BCAST_ALL: assert property ( // R4
		push_word && cmd_bcast && (q_full_reg == '0) |=> q_empty_reg == '0)
		else $error("broadcast did not reach every queue");
	AST_STEP_HOLD: assert property ( // R2
		step_valid_reg && !step_ready
		|=> step_valid_reg && $stable(step_byte_reg) && $stable(step_chan_reg))
		else $error("step changed before it was taken");
	AST_A_RD_PREFIX: assert property ( // R8
		start_evt && (head_code == FL_A_SLC_RD)
		|-> ##2 step_valid_reg && (step_kind_reg == K_OPC) && (step_byte_reg == PFX_A))
		else $error("vendor-A read did not open with its prefix");
	AST_A_WR_PREFIX: assert property ( // R9
		start_evt && (head_code == FL_A_SLC_WR)
		|-> ##2 step_valid_reg && (step_kind_reg == K_OPC) && (step_byte_reg == PFX_A))
		else $error("vendor-A write did not open with its prefix");
	AST_TLC_PREFIX: assert property ( // R10
		start_evt && (head_code >= FL_TLC_L_RD) && (head_code <= FL_TLC_U_RD)
		|-> ##2 step_valid_reg && (step_byte_reg == PFX_TLC_L + ($past(head_code, 2) - FL_TLC_L_RD)))
		else $error("TLC read prefix wrong");
	AST_TLC_SP_PREFIX: assert property ( // R11
		start_evt && (head_code >= FL_TLC_L_SP) && (head_code <= FL_TLC_U_SP)
		|-> ##2 step_valid_reg && (step_byte_reg == PFX_TLC_L + ($past(head_code, 2) - FL_TLC_L_SP)))
		else $error("TLC spare read prefix wrong");
	AST_B_SLC_PREFIX: assert property ( // R12
		start_evt && (head_code >= FL_B_SLC_PRS) && (head_code <= FL_B_SLC_ER)
		|-> ##2 step_valid_reg && (step_byte_reg == PFX_B_SLC))
		else $error("vendor-B SLC prefix wrong");
	AST_B_TLC_PREFIX: assert property ( // R13
		start_evt && (head_code >= FL_B_TLC_ER) && (head_code <= FL_B_TLC_SR)
		|-> ##2 step_valid_reg && (step_byte_reg == PFX_B_TLC))
		else $error("vendor-B TLC prefix wrong");
	AST_END_FREES: assert property ( // R15
		end_evt && !push_ch[cur_ch_reg]
		|=> cmd_done_reg && (qcnt_reg[$past(cur_ch_reg)] == $past(qcnt_reg[cur_ch_reg]) - 1))
		else $error("terminate did not free the slot");
	AST_CALL_JUMP: assert property ( // R16
		run && (rif.kind == K_CALL) |=> (pc_reg == $past(rif.arg)) && (sp_reg == $past(sp_reg) + 1))
		else $error("call did not enter the routine");
	AST_RET_RESUME: assert property ( // R16
		run && (rif.kind == K_RET) |=> pc_reg == $past(ret_pc))
		else $error("return did not resume the caller");

	COV_DONE:  cover property (cmd_done_reg);
	COV_BCAST: cover property (push_word && cmd_bcast);
	COV_LOOP:  cover property (run && (rif.kind == K_LOOP) && (cnt_reg > 8'h01));
	COV_FULL:  cover property (q_full_reg != '0);
endmodule : nand_flow_sequencer_cmd_queue

// ---- tb/flash_engine_model.sv ----
// far-side channel engine: takes steps and logs their bytes
`timescale 1ns/10ps
module flash_engine_model import seq_pkg::*; (
	input  wire logic        clk,         // clock
	input  wire logic        step_valid,  // step offered
	input  step_kind_t       step_kind,   // kind of the step
	input  wire logic [7:0]  step_byte,   // step byte
	input  wire logic [31:0] step_addr,   // address value of the step
	input  wire logic        stall,       // hold off every step
	input  wire logic        clr,         // clear the log
	output logic             step_ready,  // step taken
	output logic [7:0]       log_b [0:7], // first bytes taken
	output int               n_taken,     // steps taken since clear
	output logic [31:0]      addr_seen    // value of the last address step taken
);
	// a stalled engine keeps the sequencer waiting on one step
	assign step_ready = !stall;
	// log each step taken
	always_ff @(posedge clk) begin
		if (clr)
			n_taken <= 0;
		else if (step_valid && step_ready) begin
			if (n_taken < 8)
				log_b[n_taken[2:0]] <= step_byte;
			n_taken <= n_taken + 1;
		end
	end
	// keep the value of the last address step taken
	always_ff @(posedge clk) begin
		if (step_valid && step_ready && (step_kind == K_ADR))
			addr_seen <= step_addr;
	end
endmodule : flash_engine_model

// ---- tb/nand_flow_sequencer_cmd_queue_tb_top.sv ----
// bench of the flow sequencer and its command queues
`timescale 1ns/10ps
module nand_flow_sequencer_cmd_queue_tb_top;
	import seq_pkg::*;
	logic clk, sys_rst, cmd_wr, cmd_bcast, step_valid, step_ready;
	logic cmd_done, busy, stall, clr;
	logic [2:0] cmd_wsel;
	logic [1:0] cmd_chan, done_chan, step_chan;
	logic [31:0] step_addr, addr_seen;
	step_kind_t step_kind;
	logic [31:0] cmd_wdata;
	logic [3:0] q_full, q_empty;
	logic [7:0] step_byte;
	logic [7:0] log_b [0:7];
	int n_taken, n_fail, total_checks;
	logic [7:0] tc [10] = '{8'h00, 8'h01, 8'h03, 8'h05, 8'h08, 8'h0b, 8'h0d, 8'h0e, 8'h0f, 8'h11};
	logic [7:0] t0 [10] = '{8'ha2, 8'ha2, 8'h02, 8'h01, 8'hda, 8'hda, 8'hda, 8'hdf, 8'hdf, 8'hee};
	logic [7:0] t1 [10] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h80, 8'h60, 8'h60, 8'h00, 8'h01};
	logic [31:0] ta [10] = '{32'h80, 32'h80, 32'h80, 32'h40, 32'h00, 32'h40, 32'h40, 32'h40,
		32'h00, 32'h40};
	int tn [10] = '{74, 66, 37, 16, 21, 12, 8, 8, 21, 10};
	nand_flow_sequencer_cmd_queue nand_flow_sequencer_cmd_queue_inst (.clk(clk),
		.sys_rst(sys_rst), .cmd_wr(cmd_wr), .cmd_wsel(cmd_wsel), .cmd_chan(cmd_chan),
		.cmd_bcast(cmd_bcast), .cmd_wdata(cmd_wdata), .q_full(q_full), .q_empty(q_empty),
		.step_valid(step_valid), .step_kind(step_kind), .step_byte(step_byte),
		.step_addr(step_addr), .step_chan(step_chan), .step_ready(step_ready), .cmd_done(cmd_done),
		.done_chan(done_chan), .busy(busy));
	flash_engine_model flash_engine_model_inst (.clk(clk), .step_valid(step_valid),
		.step_kind(step_kind), .step_byte(step_byte), .step_addr(step_addr), .stall(stall),
		.clr(clr), .step_ready(step_ready), .log_b(log_b), .n_taken(n_taken),
		.addr_seen(addr_seen));
	// clock at 50 MHz
	initial begin
		clk = 0;
		forever #10 clk = ~clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic results();
		$display("checks=%0d mismatches=%0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results
	// one command word, held through the next edge
	task automatic wr(input logic [2:0] w, input logic [1:0] c, input logic b,
		input logic [31:0] d);
		@(posedge clk);
		#1 {cmd_wr, cmd_wsel, cmd_chan, cmd_bcast, cmd_wdata} = {1'b1, w, c, b, d};
	endtask : wr
	task automatic idle();
		@(posedge clk);
		#1 cmd_wr = 0;
	endtask : idle
	task automatic wait_done(input int n);
		int k;
		k = 0;
		for (int i = 0; i < 4000 && k < n; i++) begin
			@(posedge clk);
			#1 if (cmd_done === 1'b1) k++;
		end
		if (k < n) begin
			n_fail++;
			results();
		end
	endtask : wait_done
	// one flow, counter 2: check its first two bytes, last address, step count and end
	task automatic flow(input logic [7:0] code, b0, b1, input logic [31:0] a, input int n,
		input logic [1:0] ch);
		clr = 1;
		@(posedge clk);
		#1 clr = 0;
		wr(WSEL_ROW, ch, 0, 32'h0000_0040);
		wr(WSEL_TOG, ch, 0, 32'h0000_0080);
		wr(WSEL_PUSH, ch, 0, {16'h0, 8'h02, code});
		idle();
		wait_done(1);
		chk(done_chan, ch);
		chk(log_b[0], b0);
		chk(log_b[1], b1);
		chk(addr_seen, a);
		chk(n_taken, n);
	endtask : flow
	// fill a queue while the engine stalls, then broadcast
	task automatic queues();
		stall = 1;
		wr(WSEL_PUSH, 0, 0, {24'h0, FL_B_SLC_ER});
		for (int i = 0; i < 4; i++)
			wr(WSEL_PUSH, 2, 0, {24'h0, FL_B_SLC_ER});
		for (int w = 1; w < 7; w++)
			if (w != 4)
				wr(w[2:0], 1, 0, 32'h0000_0001);
		idle();
		chk(q_full, 4'h4);
		chk(q_empty[1], 1'b1);
		chk({busy, step_valid, step_kind, step_chan, step_byte}, {2'h3, K_PFX, 2'h0, PFX_B_SLC});
		wr(WSEL_PUSH, 1, 0, {24'h0, FL_B_SLC_ER});
		wr(WSEL_PUSH, 0, 1, {24'h0, FL_B_SLC_ER});
		idle();
		chk(q_empty, 4'h0);
		chk(q_full, 4'h4);
		stall = 0;
		wait_done(9);
		chk(q_empty, 4'hf);
	endtask : queues
	initial begin
		{sys_rst, cmd_wr, cmd_wsel, cmd_chan, cmd_bcast, cmd_wdata} = {1'b1, 39'h0};
		{stall, clr, n_fail, total_checks} = 0;
		repeat (16) @(posedge clk);
		#1 sys_rst = 0;
		chk({q_full, q_empty, busy}, 9'h1e);
		for (int i = 0; i < 10; i++)
			flow(tc[i], t0[i], t1[i], ta[i], tn[i], i[1:0]);
		queues();
		results();
	end
endmodule : nand_flow_sequencer_cmd_queue_tb_top
